// ===== verilog/rsf_pkg.sv
// Package: register map, field layout and carrier types of the ramp spread and fault bank
package rsf_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_SPREAD_MODE   = 8'h6b; // spread_mode_control
    localparam logic [7:0] OFS_SPREAD_RANGE  = 8'h6c; // spread_range_control
    localparam logic [7:0] OFS_RAMP_DIVISOR  = 8'h6d; // ramp_frequency_divisor
    localparam logic [7:0] OFS_TRI_STEP      = 8'h6e; // triangle_step_control
    localparam logic [7:0] OFS_AMP_BOUNDARY  = 8'h6f; // ramp_amp_boundary
    localparam logic [7:0] OFS_CHANNEL_FAULT_STATUS    = 8'h70; // channel_fault_status
    localparam logic [7:0] OFS_GLOBAL_A      = 8'h71; // global_fault_status_a
    localparam logic [7:0] OFS_GLOBAL_B      = 8'h72; // global_fault_status_b
    localparam logic [7:0] OFS_TEMP_WARN     = 8'h73; // temperature_warning_status
    localparam logic [7:0] OFS_FAULT_CLEAR   = 8'h78; // fault clear, bit 7 self-clearing

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_SPREAD_MODE   = 8'h00;
    localparam logic [7:0] RST_SPREAD_RANGE  = 8'h00;
    localparam logic [7:0] RST_RAMP_DIVISOR  = 8'h50;
    localparam logic [7:0] RST_TRI_STEP      = 8'h11;
    localparam logic [7:0] RST_AMP_BOUNDARY  = 8'h24;
    localparam logic [6:0] RST_CLEAR_SPARE   = 7'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_PRE_DIV        = 5; // spread_mode_control
    localparam int BIT_MANUAL         = 4;
    localparam int BIT_RANDOM_EN      = 1;
    localparam int BIT_TRIANGLE_EN    = 0;
    localparam int RANDOM_RANGE_LSB   = 4; // spread_range_control, 3 bits
    localparam int TRIANGLE_CTRL_LSB  = 0; // 4 bits
    localparam int FALL_STEP_LSB      = 4; // triangle_step_control, 4 bits
    localparam int RISE_STEP_LSB      = 0; // 4 bits
    localparam int AMPLITUDE_LSB      = 5; // ramp_amp_boundary, 2 bits
    localparam int BOUNDARY_LSB       = 0; // 5 bits
    localparam int BIT_FAULT_CLEAR    = 7; // fault clear register
    localparam int BIT_LEFT_DC        = 3; // channel_fault_status
    localparam int BIT_RIGHT_DC       = 2;
    localparam int BIT_LEFT_OC        = 1;
    localparam int BIT_RIGHT_OC       = 0;
    localparam int BIT_OTP_CRC        = 7; // global_fault_status_a
    localparam int BIT_COEF_WR        = 6;
    localparam int BIT_CLK_FAULT      = 2;
    localparam int BIT_SUPPLY_OV      = 1;
    localparam int BIT_SUPPLY_UV      = 0;
    localparam int BIT_THERMAL_SD     = 0; // global_fault_status_b
    localparam int BIT_THERMAL_WARN   = 2; // temperature_warning_status

    // ****************************************
    // Ramp timing and thresholds
    // ****************************************
    localparam int unsigned RAMP_BASE_HZ      = 61440000; // manual ramp = base / divisor
    localparam int          WARN_THRESHOLD_C  = 135;      // comparator trip, degrees C
    localparam int          FAULT_W           = 11;       // flags in rsf_fault_t

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic       preDivSel;       // PLL/2 source in manual mode
        logic       manualMode;      // manual fields take effect
        logic       randomSpreadEnable;
        logic       triangleEnable;
        logic [2:0] randomSpreadRange;
        logic [3:0] triangleCtrl;    // triangle frequency and range
        logic [7:0] manualRampDivisor;
        logic [3:0] triangleFallStep;
        logic [3:0] triangleRiseStep;
        logic [1:0] manualRampAmplitude;
        logic [4:0] trianglePeriodBoundary;
    } rsf_spread_cfg_t;

    typedef struct packed {
        logic leftDcFault;
        logic rightDcFault;
        logic leftOvercurrentFault;
        logic rightOvercurrentFault;
        logic otpCrcError;
        logic coefficientWriteError;
        logic clockFault;
        logic supplyOvervoltageFlag;
        logic supplyUndervoltageFlag;
        logic thermalShutdownFlag;
        logic thermalWarningFlag;
    } rsf_fault_t;

endpackage

// ===== verilog/rsf_regs.sv
// Ramp spread-spectrum configuration and fault status register bank
`timescale 1ns/1ps
module rsf_regs
    import rsf_pkg::*;
(
    input  wire logic            sys_clk,    // 100 MHz register clock
    input  wire logic            reset_n,    // Async, active low
    input  wire logic            regWrite,   // Write strobe, one cycle
    input  wire logic            regRead,    // Read strobe, one cycle
    input  wire logic [7:0]      regAddr,    // Register offset
    input  wire logic [7:0]      regWdata,   // Write data
    output logic      [7:0]      regRdata,   // Read data, held until next read
    input  wire rsf_fault_t      faultRaw,   // Detector levels, asynchronous
    output rsf_fault_t           faultFlags, // Latched fault flags
    output rsf_spread_cfg_t      spreadCfg,  // Configuration to ramp controller
    output logic                 rampPreDivActive // Ramp runs on PLL/2
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0]         spreadMode;     // Reserved bits kept, read back
    logic [7:0]         spreadRange;
    logic [7:0]         rampDivisor;
    logic [7:0]         triStep;
    logic [7:0]         ampBoundary;
    logic [6:0]         clearSpare;     // Spare bits of the clear register
    logic [FAULT_W-1:0] faultSync1;     // First synchroniser stage only
    logic [FAULT_W-1:0] faultSync2;     // Safe to read
    logic [FAULT_W-1:0] faultLatch;     // Sticky flags
    logic               clearPulse;     // Fault clear strobe
    rsf_fault_t         latchView;      // Named view of the sticky flags

    assign latchView = rsf_fault_t'(faultLatch);

    // Clear only on a write with bit 7 set; the bit itself never stores
    assign clearPulse = regWrite && (regAddr == OFS_FAULT_CLEAR)
                        && regWdata[BIT_FAULT_CLEAR];

    // ****************************************
    // Writable registers
    // ****************************************
    // Software writes; fault status offsets have no branch here
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            spreadMode  <= RST_SPREAD_MODE;
            spreadRange <= RST_SPREAD_RANGE;
            rampDivisor <= RST_RAMP_DIVISOR;
            triStep     <= RST_TRI_STEP;
            ampBoundary <= RST_AMP_BOUNDARY;
            clearSpare  <= RST_CLEAR_SPARE;
        end else if (regWrite) begin
            case (regAddr)
                OFS_SPREAD_MODE:  spreadMode  <= regWdata;
                OFS_SPREAD_RANGE: spreadRange <= regWdata;
                OFS_RAMP_DIVISOR: rampDivisor <= regWdata;
                OFS_TRI_STEP:     triStep     <= regWdata;
                OFS_AMP_BOUNDARY: ampBoundary <= regWdata;
                OFS_FAULT_CLEAR:  clearSpare  <= regWdata[6:0];
                default: begin
                    // Status and unmapped offsets ignore writes
                end
            endcase
        end
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    // Registered copy of the fields, one cycle behind the register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            spreadCfg        <= '0;
            rampPreDivActive <= 1'b0;
        end else begin
            spreadCfg.preDivSel              <= spreadMode[BIT_PRE_DIV];
            spreadCfg.manualMode             <= spreadMode[BIT_MANUAL];
            spreadCfg.randomSpreadEnable     <= spreadMode[BIT_RANDOM_EN];
            spreadCfg.triangleEnable         <= spreadMode[BIT_TRIANGLE_EN];
            spreadCfg.randomSpreadRange      <= spreadRange[RANDOM_RANGE_LSB +: 3];
            spreadCfg.triangleCtrl           <= spreadRange[TRIANGLE_CTRL_LSB +: 4];
            spreadCfg.manualRampDivisor      <= rampDivisor;
            spreadCfg.triangleFallStep       <= triStep[FALL_STEP_LSB +: 4];
            spreadCfg.triangleRiseStep       <= triStep[RISE_STEP_LSB +: 4];
            spreadCfg.manualRampAmplitude    <= ampBoundary[AMPLITUDE_LSB +: 2];
            spreadCfg.trianglePeriodBoundary <= ampBoundary[BOUNDARY_LSB +: 5];
            // Pre-divide only matters once manual mode is on
            rampPreDivActive <= spreadMode[BIT_PRE_DIV] & spreadMode[BIT_MANUAL];
        end
    end

    // ****************************************
    // Fault capture
    // ****************************************
    // Detector levels are analogue-side, so two flops before any use
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            faultSync1 <= '0;
            faultSync2 <= '0;
        end else begin
            faultSync1 <= faultRaw;
            faultSync2 <= faultSync1;
        end
    end

    // Sticky per flag; a live fault beats the clear, so none is lost
    for (genvar i = 0; i < FAULT_W; i++) begin : g_latch
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                faultLatch[i] <= 1'b0;
            end else if (faultSync2[i]) begin
                faultLatch[i] <= 1'b1;
            end else if (clearPulse) begin
                faultLatch[i] <= 1'b0;
            end
        end
    end

    // Flag outputs track the latch one cycle later
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            faultFlags <= '0;
        end else begin
            faultFlags <= latchView;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Data lands one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= 8'h00;
            case (regAddr)
                OFS_SPREAD_MODE:  regRdata <= spreadMode;
                OFS_SPREAD_RANGE: regRdata <= spreadRange;
                OFS_RAMP_DIVISOR: regRdata <= rampDivisor;
                OFS_TRI_STEP:     regRdata <= triStep;
                OFS_AMP_BOUNDARY: regRdata <= ampBoundary;
                OFS_CHANNEL_FAULT_STATUS: begin
                    regRdata[BIT_LEFT_DC]  <= latchView.leftDcFault;
                    regRdata[BIT_RIGHT_DC] <= latchView.rightDcFault;
                    regRdata[BIT_LEFT_OC]  <= latchView.leftOvercurrentFault;
                    regRdata[BIT_RIGHT_OC] <= latchView.rightOvercurrentFault;
                end
                OFS_GLOBAL_A: begin
                    regRdata[BIT_OTP_CRC]   <= latchView.otpCrcError;
                    regRdata[BIT_COEF_WR]   <= latchView.coefficientWriteError;
                    regRdata[BIT_CLK_FAULT] <= latchView.clockFault;
                    regRdata[BIT_SUPPLY_OV] <= latchView.supplyOvervoltageFlag;
                    regRdata[BIT_SUPPLY_UV] <= latchView.supplyUndervoltageFlag;
                end
                OFS_GLOBAL_B: begin
                    // Upper bits stay zero from the default above
                    regRdata[BIT_THERMAL_SD] <= latchView.thermalShutdownFlag;
                end
                OFS_TEMP_WARN: begin
                    regRdata[BIT_THERMAL_WARN] <= latchView.thermalWarningFlag;
                end
                OFS_FAULT_CLEAR: regRdata <= {1'b0, clearSpare}; // Bit 7 self-clears
                default: begin
                    // Unmapped: zero
                end
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // All checks sample on the register clock and sleep in reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_prediv;
        regWrite && regAddr == OFS_SPREAD_MODE && regWdata[BIT_PRE_DIV] && regWdata[BIT_MANUAL]
            ##1 !regWrite |=> rampPreDivActive;
    endproperty
    a_prediv: assert property (p_prediv) else $error("pre-divide not active");

    property p_manual;
        regWrite && regAddr == OFS_SPREAD_MODE |-> ##2 spreadCfg.manualMode == $past(regWdata[4], 2);
    endproperty
    a_manual: assert property (p_manual) else $error("manual mode wrong");

    property p_random;
        regWrite && regAddr == OFS_SPREAD_RANGE |-> ##2
            spreadCfg.randomSpreadRange == $past(regWdata[6:4], 2);
    endproperty
    a_random: assert property (p_random) else $error("random range wrong");

    property p_triangle;
        regWrite && regAddr == OFS_SPREAD_RANGE |-> ##2
            spreadCfg.triangleCtrl == $past(regWdata[3:0], 2);
    endproperty
    a_triangle: assert property (p_triangle) else $error("triangle control wrong");

    property p_divisor;
        regWrite && regAddr == OFS_RAMP_DIVISOR |-> ##2
            spreadCfg.manualRampDivisor == $past(regWdata, 2);
    endproperty
    a_divisor: assert property (p_divisor) else $error("divisor wrong");

    property p_steps;
        regWrite && regAddr == OFS_TRI_STEP |-> ##2
            {spreadCfg.triangleFallStep, spreadCfg.triangleRiseStep} == $past(regWdata, 2);
    endproperty
    a_steps: assert property (p_steps) else $error("step fields wrong");

    property p_ampbound;
        regWrite && regAddr == OFS_AMP_BOUNDARY |-> ##2
            {spreadCfg.manualRampAmplitude, spreadCfg.trianglePeriodBoundary}
            == $past(regWdata[6:0], 2);
    endproperty
    a_ampbound: assert property (p_ampbound) else $error("amp or boundary wrong");

    // Four edges: two sync stages, the latch, the output flop
    property p_dcfault;
        faultRaw.leftDcFault |-> ##3 faultLatch[FAULT_W-1] ##1 faultFlags.leftDcFault;
    endproperty
    a_dcfault: assert property (p_dcfault) else $error("DC fault not latched");

    property p_thermal;
        faultRaw.thermalWarningFlag |-> ##4 faultFlags.thermalWarningFlag;
    endproperty
    a_thermal: assert property (p_thermal) else $error("warning not latched");

    // Reserved bits of the second global byte
    property p_globalb;
        regRead && regAddr == OFS_GLOBAL_B |=> regRdata[7:1] == 7'h00;
    endproperty
    a_globalb: assert property (p_globalb) else $error("reserved bits not zero");

    property p_ignore;
        faultLatch != '0 && regWrite && regAddr >= OFS_CHANNEL_FAULT_STATUS && regAddr <= OFS_TEMP_WARN
            |=> (faultLatch & $past(faultLatch)) == $past(faultLatch);
    endproperty
    a_ignore: assert property (p_ignore) else $error("fault write changed flag");

    // Clear with every detector quiet empties the latch
    property p_clear;
        clearPulse && faultSync2 == '0 |=> faultLatch == '0 ##1 faultFlags == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("fault clear failed");

    // ****************************************
    // Read-path, flag-path, status-write and pre-divide checks
    // ****************************************
    // Over-current takes the same four-edge path
    property p_ocfault;
        faultRaw.rightOvercurrentFault |-> ##4 faultFlags.rightOvercurrentFault;
    endproperty
    a_ocfault: assert property (p_ocfault) else $error("over-current not latched");

    // Failed coefficient write reaches the flag port
    property p_coefwr;
        faultRaw.coefficientWriteError |-> ##4 faultFlags.coefficientWriteError;
    endproperty
    a_coefwr: assert property (p_coefwr) else $error("coef error not latched");

    // Channel byte: four flags low, upper nibble zero
    property p_chanread;
        regRead && regAddr == OFS_CHANNEL_FAULT_STATUS |=> regRdata == {4'h0,
            $past(latchView.leftDcFault), $past(latchView.rightDcFault),
            $past(latchView.leftOvercurrentFault), $past(latchView.rightOvercurrentFault)};
    endproperty
    a_chanread: assert property (p_chanread) else $error("channel byte wrong");

    // First global byte: bits 5..3 always zero
    property p_globala;
        regRead && regAddr == OFS_GLOBAL_A |=> regRdata == {
            $past(latchView.otpCrcError), $past(latchView.coefficientWriteError), 3'h0,
            $past(latchView.clockFault), $past(latchView.supplyOvervoltageFlag),
            $past(latchView.supplyUndervoltageFlag)};
    endproperty
    a_globala: assert property (p_globala) else $error("global byte wrong");

    // Warning byte: single flag in bit 2
    property p_warnread;
        regRead && regAddr == OFS_TEMP_WARN |=>
            regRdata == {5'h00, $past(latchView.thermalWarningFlag), 2'h0};
    endproperty
    a_warnread: assert property (p_warnread) else $error("warning byte wrong");

    // Self-clearing bit never reads back as one
    property p_clearbit;
        regRead && regAddr == OFS_FAULT_CLEAR |=> !regRdata[BIT_FAULT_CLEAR];
    endproperty
    a_clearbit: assert property (p_clearbit) else $error("clear bit read as one");

    // Detector still high at the clear keeps its flag
    property p_setwins;
        clearPulse && faultSync2 != '0
            |=> (faultLatch & $past(faultSync2)) == $past(faultSync2);
    endproperty
    a_setwins: assert property (p_setwins) else $error("live fault was cleared");

    // No flag drops without a clear strobe
    property p_sticky;
        !clearPulse |=> (faultLatch & $past(faultLatch)) == $past(faultLatch);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped unasked");

    // Status writes must not disturb any stored byte
    property p_statuswr;
        regWrite && regAddr >= OFS_CHANNEL_FAULT_STATUS && regAddr <= OFS_TEMP_WARN |=>
            $stable({spreadMode, spreadRange, rampDivisor, triStep, ampBoundary, clearSpare});
    endproperty
    a_statuswr: assert property (p_statuswr) else $error("status write stored");

    // Outside manual mode the ramp never runs on PLL/2
    property p_predivoff;
        !spreadMode[BIT_MANUAL] |=> !rampPreDivActive;
    endproperty
    a_predivoff: assert property (p_predivoff) else $error("stray pre-divide");

    // Main scenarios worth seeing in a run
    c_manual: cover property (regWrite && regAddr == OFS_SPREAD_MODE && regWdata[BIT_MANUAL]);
    c_fault:  cover property ($rose(faultFlags.otpCrcError));
    c_clear:  cover property (clearPulse && faultLatch != '0);
    c_race:   cover property (clearPulse && faultSync2 != '0);

endmodule

// ===== tb/testbench.sv
// Self-checking bench for the ramp spread and fault status register bank
`timescale 1ns/1ps
module testbench;
    import rsf_pkg::*;

    // ****************************************
    // Stimulus and observation signals
    // ****************************************
    logic            sys_clk;          // 100 MHz
    logic            reset_n;          // Async, active low
    logic            regWrite;         // Write strobe
    logic            regRead;          // Read strobe
    logic [7:0]      regAddr;          // Offset
    logic [7:0]      regWdata;         // Write byte
    logic [7:0]      regRdata;         // Read byte
    rsf_fault_t      faultRaw;         // Detector levels
    rsf_fault_t      faultFlags;       // Latched flags
    rsf_spread_cfg_t spreadCfg;        // Config to ramp
    logic            rampPreDivActive; // PLL/2 in use
    logic [7:0]      readByte;         // Last byte read
    int              failures;         // Mismatch count
    int              checks_done;      // Comparison count
    int              cycleCount;       // Hang guard

    rsf_regs rsf_regs_i (
        .sys_clk          (sys_clk),
        .reset_n          (reset_n),
        .regWrite         (regWrite),
        .regRead          (regRead),
        .regAddr          (regAddr),
        .regWdata         (regWdata),
        .regRdata         (regRdata),
        .faultRaw         (faultRaw),
        .faultFlags       (faultFlags),
        .spreadCfg        (spreadCfg),
        .rampPreDivActive (rampPreDivActive)
    );

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run needs about 520 cycles, so 5000 means a stuck wait
    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount == 5000) begin
            failures++;
            close_out();
        end
    end

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input logic [36:0] seen, input logic [36:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // Strobes change on the falling edge, held over one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regWrite = 1'b1;
        regAddr  = a;
        regWdata = d;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask

    // Extra cycle of slack: read data holds until the next read anyway
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge sys_clk);
        regRead = 1'b0;
        @(negedge sys_clk);
        readByte = regRdata;
    endtask

    // Expected status byte for one fault pattern
    function automatic logic [7:0] stat(input rsf_fault_t f, input logic [7:0] a);
        case (a)
            8'h70:   return {4'h0, f.leftDcFault, f.rightDcFault,
                             f.leftOvercurrentFault, f.rightOvercurrentFault};
            8'h71:   return {f.otpCrcError, f.coefficientWriteError, 3'h0, f.clockFault,
                             f.supplyOvervoltageFlag, f.supplyUndervoltageFlag};
            8'h72:   return {7'h00, f.thermalShutdownFlag};
            default: return {5'h00, f.thermalWarningFlag, 2'h0};
        endcase
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset, then every register and the config port at reset value
    task automatic do_reset();
        logic [7:0] rstTab [10];
        rstTab = '{8'h00, 8'h00, 8'h50, 8'h11, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(faultFlags, 37'h0);
        check(spreadCfg, 37'h0);
        check({rampPreDivActive, regRdata}, 9'h000);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(spreadCfg.manualMode, 1'b0);
        check(spreadCfg.manualRampDivisor, 8'h50);
        check({spreadCfg.triangleFallStep, spreadCfg.triangleRiseStep}, 8'h11);
        check(spreadCfg.manualRampAmplitude, 2'h1);
        check(spreadCfg.trianglePeriodBoundary, 5'h04);
        for (int k = 0; k < 10; k++) begin
            rd((k == 9) ? OFS_FAULT_CLEAR : 8'(8'h6b + k));
            check(readByte, rstTab[k]);
        end
    endtask

    // Every spread field written away from reset and seen on the port
    task automatic t_config();
        logic [7:0] pat [5];
        pat = '{8'h33, 8'h5a, 8'hff, 8'hc3, 8'hdf};
        for (int k = 0; k < 5; k++) begin
            wr(8'(8'h6b + k), pat[k]);
        end
        repeat (2) @(negedge sys_clk);
        check({spreadCfg.preDivSel, rampPreDivActive}, 2'b11);
        check(spreadCfg.manualMode, 1'b1);
        check({spreadCfg.randomSpreadEnable, spreadCfg.randomSpreadRange}, 4'hd);
        check({spreadCfg.triangleEnable, spreadCfg.triangleCtrl}, 5'h1a);
        check(spreadCfg.manualRampDivisor, 8'hff);
        check(spreadCfg.triangleFallStep, 4'hc);
        check(spreadCfg.triangleRiseStep, 4'h3);
        check(spreadCfg.manualRampAmplitude, 2'h2);
        check(spreadCfg.trianglePeriodBoundary, 5'h1f);
        for (int k = 0; k < 5; k++) begin
            rd(8'(8'h6b + k));
            check(readByte, pat[k]);
        end
        // Pre-divide alone, then manual alone: source switch needs both
        wr(OFS_SPREAD_MODE, 8'h20);
        repeat (2) @(negedge sys_clk);
        check({spreadCfg.preDivSel, rampPreDivActive}, 2'b10);
        wr(OFS_SPREAD_MODE, 8'h10);
        repeat (2) @(negedge sys_clk);
        check({spreadCfg.manualMode, rampPreDivActive}, 2'b10);
    endtask

    // Each detector alone: bit position, stickiness, refused clear, clear
    task automatic t_faults();
        rsf_fault_t want;
        for (int i = 0; i < FAULT_W; i++) begin
            want = rsf_fault_t'(11'h001 << i);
            @(negedge sys_clk);
            faultRaw = want;
            repeat (5) @(negedge sys_clk);
            check(faultFlags, want);
            // Status bytes are read-only, so this write must change nothing
            wr(8'(8'h70 + (i % 4)), 8'hff);
            for (int k = 0; k < 4; k++) begin
                rd(8'(8'h70 + k));
                check(readByte, stat(want, 8'(8'h70 + k)));
            end
            // Clear while the fault persists: flag must survive
            wr(OFS_FAULT_CLEAR, 8'h80);
            repeat (3) @(negedge sys_clk);
            check(faultFlags, want);
            faultRaw = '0;
            repeat (5) @(negedge sys_clk);
            check(faultFlags, want);
            wr(OFS_FAULT_CLEAR, 8'h80);
            repeat (3) @(negedge sys_clk);
            check(faultFlags, 37'h0);
        end
        rd(OFS_FAULT_CLEAR);
        check(readByte, 8'h00);
        // Spare bits store, the clear bit itself never reads back
        wr(OFS_FAULT_CLEAR, 8'hff);
        rd(OFS_FAULT_CLEAR);
        check(readByte, 8'h7f);
        // Unmapped place: write dropped, read gives zero
        wr(8'h7f, 8'ha5);
        rd(8'h7f);
        check(readByte, 8'h00);
    endtask

    // ****************************************
    // Verdict
    // ****************************************
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_n     = 1'b0;
        regWrite    = 1'b0;
        regRead     = 1'b0;
        regAddr     = 8'h00;
        regWdata    = 8'h00;
        faultRaw    = '0;
        readByte    = 8'h00;
        failures    = 0;
        checks_done = 0;
        cycleCount  = 0;
        do_reset();
        t_config();
        t_faults();
        // Second reset in mid-run must restore everything
        do_reset();
        close_out();
    end
endmodule
